// ===== rtl/fbp_defs.svh
// Constants for the flash block protection checker.
// Assumes byte addressing of a 96 KB array starting at offset zero.
`ifndef FBP_DEFS_SVH
`define FBP_DEFS_SVH
`define FBP_FLASH_BYTES   17'h18000
`define FBP_ADDR_W        17
`define FBP_SECTOR_LSB    10
`define FBP_REGION_LSB    11
`define FBP_SECTORS       96
`define FBP_REGIONS       48
`define FBP_SECT_W        7
`define FBP_REG_W         6
`define FBP_ERASE_WORD    32'hFFFFFFFF
`endif

// ===== rtl/fbp_pkg.sv
// Types shared by the flash block protection checker.
// Assumes fbp_defs.svh supplies the numeric constants.
`include "fbp_defs.svh"
package fbp_pkg;
    // =====================================================
    // Request operation and source
    typedef enum logic [1:0] {
        FBP_OP_READ    = 2'b00,
        FBP_OP_PROGRAM = 2'b01,
        FBP_OP_ERASE   = 2'b10
    } fbp_op_type;

    typedef enum logic [1:0] {
        FBP_SRC_IFETCH = 2'b00,
        FBP_SRC_DATA   = 2'b01,
        FBP_SRC_DEBUG  = 2'b10
    } fbp_src_type;

    typedef struct packed {
        fbp_op_type                 op;
        fbp_src_type                src;
        logic [`FBP_ADDR_W-1:0]     addr;
        logic [31:0]                wdata;
    } fbp_req_type;

    // Per region protection bits
    typedef struct packed {
        logic read_only;
        logic exec_only;
    } fbp_prot_type;
endpackage : fbp_pkg

// ===== rtl/fbp_check.sv
// Protection decision for one request against the region table.
// Assumes a protection vector held steady by the surrounding logic.
`timescale 1ns/10ps
`default_nettype none
`include "fbp_defs.svh"
module fbp_check #(
    parameter int REGIONS = `FBP_REGIONS
) (
    // Request
    input  var fbp_pkg::fbp_req_type          req,
    // Region table
    input  var fbp_pkg::fbp_prot_type [REGIONS-1:0] prot,
    // Decision
    output logic                              in_range,
    output logic                              allow
);
    wire [`FBP_REG_W-1:0]  region_idx;
    wire fbp_pkg::fbp_prot_type p_sel;
    wire is_write;
    wire is_ifetch;

    // [RL4] region from sector pair
    assign region_idx = req.addr[`FBP_ADDR_W-1:`FBP_REGION_LSB];
    // [RL1] whole range decode
    assign in_range   = req.addr < `FBP_FLASH_BYTES;
    assign p_sel      = in_range ? prot[region_idx] : '0;
    assign is_write   = req.op != fbp_pkg::FBP_OP_READ;
    assign is_ifetch  = req.src == fbp_pkg::FBP_SRC_IFETCH;
    // [RL5] [RL6] [RL7] [RL8] protection decision
    assign allow = in_range
                 && !(is_write && (p_sel.read_only || p_sel.exec_only))
                 && !(!is_write && p_sel.exec_only && !is_ifetch);
endmodule : fbp_check
`default_nettype wire

// ===== rtl/fbp_top.sv
// Flash array with per region protection checking.
// Assumes requesters hold a request until it is acknowledged.
// Functional notes
// [RL1] The array holds 96 KB and every address in that range decodes.
// [RL2] Erase works on one 1 KB sector and touches no other sector.
// [RL3] A finished erase leaves every bit of the sector at one.
// [RL4] Protection is held per 2 KB region made of two sectors.
// [RL5] A read-only region refuses erase and program but allows reads.
// [RL6] An execute-only region refuses erase and program.
// [RL7] An execute-only region serves reads only to instruction fetch.
// [RL8] Data and debugger reads of an execute-only region are blocked.
// [RL9] A blocked request answers with an error and sets a sticky flag.
`timescale 1ns/10ps
`default_nettype none
`include "fbp_defs.svh"
module fbp_top #(
    parameter int WORDS   = `FBP_FLASH_BYTES / 4,
    parameter int REGIONS = `FBP_REGIONS
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rstn,
    // Request channel
    input  wire logic                          req_valid,
    input  var fbp_pkg::fbp_req_type           req,
    output logic                               req_ready,
    // Response
    output logic                               rsp_valid,
    output logic                               rsp_error,
    output logic [31:0]                        rsp_rdata,
    // Protection table, two bits per region
    input  var fbp_pkg::fbp_prot_type [REGIONS-1:0] prot,
    // Sticky violation flag
    input  wire logic                          viol_clear,
    output logic                               viol_flag
);
    // =====================================================
    // Storage and state
    typedef enum logic [1:0] {
        FBP_IDLE  = 2'b00,
        FBP_ERASE = 2'b01
    } fbp_state_type;

    localparam int SWORDS = (1 << `FBP_SECTOR_LSB) / 4;

    logic [31:0]             mem [WORDS];
    fbp_state_type           state_reg, state_next;
    logic [7:0]              cnt_reg;
    logic [`FBP_SECT_W-1:0]  sect_reg;
    logic                    rsp_valid_reg, rsp_error_reg, viol_reg;
    logic [31:0]             rdata_reg;

    wire in_range;
    wire allow;
    wire take;
    wire blocked;
    wire word_idx_ok;
    wire [`FBP_ADDR_W-3:0] word_idx;
    wire [`FBP_ADDR_W-3:0] erase_idx;
    wire [`FBP_REG_W-1:0]  region_idx;
    wire fbp_pkg::fbp_prot_type prot_sel;
    wire erase_done;

    fbp_check #(.REGIONS(REGIONS)) u_check (
        .req      (req),
        .prot     (prot),
        .in_range (in_range),
        .allow    (allow)
    );

    // =====================================================
    // Decode
    assign req_ready  = state_reg == FBP_IDLE;
    assign take       = req_valid && req_ready;
    assign blocked    = take && !allow;
    assign word_idx   = req.addr[`FBP_ADDR_W-1:2];
    assign word_idx_ok = in_range;
    assign erase_done = state_reg == FBP_ERASE
                     && cnt_reg == 8'(SWORDS - 1);
    assign erase_idx  = {sect_reg, cnt_reg};
    // Checker copy of the region lookup, zero outside the array
    assign region_idx = req.addr[`FBP_ADDR_W-1:`FBP_REGION_LSB];
    assign prot_sel   = in_range ? prot[region_idx] : '0;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            FBP_IDLE: begin
                if (take && allow && req.op == fbp_pkg::FBP_OP_ERASE)
                    state_next = FBP_ERASE;
            end
            FBP_ERASE: begin
                if (erase_done)
                    state_next = FBP_IDLE;
            end
            default: state_next = FBP_IDLE;
        endcase
    end

    // =====================================================
    // Control registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg     <= FBP_IDLE;
            cnt_reg       <= 8'h00;
            sect_reg      <= '0;
            rsp_valid_reg <= 1'b0;
            rsp_error_reg <= 1'b0;
            viol_reg      <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= (state_reg == FBP_ERASE) ? cnt_reg + 8'h01 : 8'h00;
            if (take)
                sect_reg <= req.addr[`FBP_ADDR_W-1:`FBP_SECTOR_LSB];
            // Erase answers when the sector walk finishes
            rsp_valid_reg <= (take && req.op != fbp_pkg::FBP_OP_ERASE)
                          || blocked || erase_done;
            // [RL9] error reply
            rsp_error_reg <= blocked;
            // [RL9] sticky flag, set wins over clear
            viol_reg <= blocked || (viol_reg && !viol_clear);
        end
    end

    // =====================================================
    // Array
    // Erase walks one word per cycle; the array has no reset by design.
    always_ff @(posedge clk) begin
        if (take && allow && req.op == fbp_pkg::FBP_OP_READ && word_idx_ok)
            rdata_reg <= mem[word_idx];
        else if (take)
            rdata_reg <= 32'h0000_0000;
        // Program can only clear bits, as flash cells do
        if (take && allow && req.op == fbp_pkg::FBP_OP_PROGRAM)
            mem[word_idx] <= mem[word_idx] & req.wdata;
        // [RL2] [RL3] sector erase to ones
        if (state_reg == FBP_ERASE)
            mem[erase_idx] <= `FBP_ERASE_WORD;
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_error = rsp_error_reg;
    assign rsp_rdata = rdata_reg;
    assign viol_flag = viol_reg;

    // =====================================================
    // Checks
    // [RL5] write to protected region
    a_ro_write_err: assert property (@(posedge clk) disable iff (!rstn) // RL5
        take && req.op != fbp_pkg::FBP_OP_READ && in_range
        && prot_sel.read_only |=> rsp_valid && rsp_error)
        else $error("write to read-only region not refused");
    // [RL6] execute-only write
    a_xo_write_err: assert property (@(posedge clk) disable iff (!rstn) // RL6
        take && req.op != fbp_pkg::FBP_OP_READ && in_range
        && prot_sel.exec_only |=> rsp_valid && rsp_error)
        else $error("write to execute-only region not refused");
    // [RL7] fetch allowed
    a_xo_fetch_ok: assert property (@(posedge clk) disable iff (!rstn) // RL7
        take && req.op == fbp_pkg::FBP_OP_READ && in_range
        && req.src == fbp_pkg::FBP_SRC_IFETCH |=> !rsp_error)
        else $error("instruction fetch wrongly refused");
    // [RL8] data read blocked
    a_xo_read_blk: assert property (@(posedge clk) disable iff (!rstn) // RL8
        take && req.op == fbp_pkg::FBP_OP_READ && in_range
        && prot_sel.exec_only
        && req.src != fbp_pkg::FBP_SRC_IFETCH
        |=> rsp_error && rsp_rdata == 32'h0000_0000)
        else $error("execute-only data leaked");
    // [RL9] flag set on refusal
    a_viol_sticky: assert property (@(posedge clk) disable iff (!rstn) // RL9
        blocked |=> viol_flag)
        else $error("violation flag not set");
    // [RL1] out of range
    a_range_err: assert property (@(posedge clk) disable iff (!rstn) // RL1
        take && !in_range |=> rsp_error)
        else $error("out of range access not refused");
    // [RL2] erase length
    a_erase_len: assert property (@(posedge clk) disable iff (!rstn) // RL2
        $rose(state_reg == FBP_ERASE) |-> ##255 erase_done)
        else $error("erase walk length wrong");
    // [RL5] region read-only permits read
    a_ro_read_ok: assert property (@(posedge clk) disable iff (!rstn) // RL5
        take && req.op == fbp_pkg::FBP_OP_READ && in_range
        && !prot_sel.exec_only |=> !rsp_error)
        else $error("read of readable region refused");
    // [RL9] flag holds until cleared
    a_viol_hold: assert property (@(posedge clk) disable iff (!rstn) // RL9
        viol_flag && !viol_clear |=> viol_flag)
        else $error("violation flag dropped without clear");
    // [RL9] clear without new violation
    a_viol_clear: assert property (@(posedge clk) disable iff (!rstn) // RL9
        viol_clear && !blocked |=> !viol_flag)
        else $error("violation flag not cleared");
    // [RL3] erased word holds ones
    a_erase_ones: assert property (@(posedge clk) disable iff (!rstn) // RL3
        state_reg == FBP_ERASE |=> mem[$past(erase_idx)] == `FBP_ERASE_WORD)
        else $error("erased word not all ones");
    // [RL3] erase answers when the walk ends
    a_erase_rsp: assert property (@(posedge clk) disable iff (!rstn) // RL3
        erase_done |=> rsp_valid && !rsp_error && req_ready)
        else $error("erase finished without answer");
    // [RL8] refused request returns no data
    a_blk_rdata: assert property (@(posedge clk) disable iff (!rstn) // RL8
        blocked |=> rsp_rdata == 32'h0000_0000)
        else $error("refused request returned data");
    // [RL8] writes return no data
    a_write_rdata: assert property (@(posedge clk) disable iff (!rstn) // RL8
        take && req.op != fbp_pkg::FBP_OP_READ |=> rsp_rdata == 32'h0000_0000)
        else $error("write answer carried data");

    // Cover points for the main scenarios
    c_erase: cover property (@(posedge clk) erase_done);
    c_block: cover property (@(posedge clk) blocked);
    c_fetch: cover property (@(posedge clk)
        take && req.src == fbp_pkg::FBP_SRC_IFETCH);
    c_xo_read: cover property (@(posedge clk)
        blocked && prot_sel.exec_only && req.op == fbp_pkg::FBP_OP_READ);
    c_set_clear: cover property (@(posedge clk) blocked && viol_clear);
endmodule : fbp_top
`default_nettype wire

// ===== dv/fbp_master.sv
// Requester model standing in for the fetch, data and debug masters.
// Assumes the block takes a request at a rising edge with ready high.
`timescale 1ns/10ps
`default_nettype none
module fbp_master (
    // Clock
    input  wire logic                 clk,
    // Request channel
    output var logic                  req_valid,
    output var fbp_pkg::fbp_req_type  req,
    input  wire logic                 req_ready
);
    // ==================================================
    // One request, held until the edge that takes it
    task automatic xfer(input fbp_pkg::fbp_req_type r, output bit ok);
        int n;
        ok = 1'b0;
        @(posedge clk);
        req_valid <= 1'b1;
        req       <= r;
        for (n = 0; n < 400 && !ok; n++) begin
            @(posedge clk);
            ok = (req_ready === 1'b1);
        end
        // Idle bus shows a changed value, not the stale one
        req_valid <= 1'b0;
        req       <= ~r;
    endtask : xfer

    initial begin
        req_valid = 1'b0;
        req       = '0;
    end
endmodule : fbp_master
`default_nettype wire

// ===== dv/flash_block_protection_test.sv
// Self-checking bench for the flash protection block.
// Assumes the requester model in fbp_master.sv drives the request side.
`timescale 1ns/10ps
`default_nettype none
`include "fbp_defs.svh"
module flash_block_protection_test;
    localparam fbp_pkg::fbp_op_type  RD = fbp_pkg::FBP_OP_READ;
    localparam fbp_pkg::fbp_op_type  PG = fbp_pkg::FBP_OP_PROGRAM;
    localparam fbp_pkg::fbp_op_type  ER = fbp_pkg::FBP_OP_ERASE;
    localparam fbp_pkg::fbp_src_type FE = fbp_pkg::FBP_SRC_IFETCH;
    localparam fbp_pkg::fbp_src_type DA = fbp_pkg::FBP_SRC_DATA;
    localparam fbp_pkg::fbp_src_type DB = fbp_pkg::FBP_SRC_DEBUG;
    localparam logic [31:0]          ONES = `FBP_ERASE_WORD;
    logic        clk, rstn, req_valid, req_ready, viol_clear, viol_flag;
    logic        rsp_valid, rsp_error;
    logic [31:0] rsp_rdata;
    int          fails, checked;
    fbp_pkg::fbp_req_type                     req;
    fbp_pkg::fbp_prot_type [`FBP_REGIONS-1:0] prot;

    fbp_master m_u (.clk(clk), .req_valid(req_valid), .req(req),
                    .req_ready(req_ready));
    fbp_top dut_u (.clk(clk), .rstn(rstn), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .prot(prot),
        .viol_clear(viol_clear), .viol_flag(viol_flag));

    always #2.5 clk = ~clk;

    // ==================================================
    // Shared compare, transfer and closing
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // d is write data for a program, expected data for a read
    task automatic op(fbp_pkg::fbp_op_type o, fbp_pkg::fbp_src_type s,
            logic [16:0] a, logic [31:0] d, logic er);
        bit          ok;
        int          n;
        int          busy;
        logic [31:0] exp_n;
        logic [31:0] exp_b;
        m_u.xfer('{o, s, a, d}, ok);
        n = 0;
        busy = 0;
        do begin
            @(posedge clk);
            n++;
            if (req_ready !== 1'b1)
                busy++;
        end while (rsp_valid !== 1'b1 && n < 300);
        if (!ok || rsp_valid !== 1'b1) begin
            fails++;
            $display("ERROR response expected 1 seen timeout");
            give_verdict();
        end else begin
            // Allowed erase: answer 257 edges after take, busy for 256 of them
            exp_n = (o == ER && !er) ? 32'h101 : 32'h1;
            exp_b = (o == ER && !er) ? 32'h100 : 32'h0;
            chk("rsp_error", 32'(er), 32'(rsp_error));
            chk("latency", exp_n, 32'(n));
            chk("busy cycles", exp_b, 32'(busy));
            if (o == RD && !er)
                chk("rsp_rdata", d, rsp_rdata);
            if (o == RD && er)
                chk("rsp_rdata", 32'h0, rsp_rdata);
            @(posedge clk);
            chk("rsp_valid", 32'h0, 32'(rsp_valid));
        end
    endtask : op

    // ==================================================
    // Scenarios
    task automatic t_erase();
        op(ER, DA, 17'h0, 32'h0, 1'h0);
        op(ER, DA, 17'h400, 32'h0, 1'h0);
        op(PG, DA, 17'h0, 32'h1234ABCD, 1'h0);
        op(PG, DB, 17'h0, 32'hFF00FFFF, 1'h0);
        op(ER, DA, 17'h400, 32'h0, 1'h0);
        op(RD, DA, 17'h0, 32'h1200ABCD, 1'h0);
        op(RD, DB, 17'h7FC, ONES, 1'h0);
        op(RD, FE, 17'h3FC, ONES, 1'h0);
        $display("t_erase done");
    endtask : t_erase

    task automatic t_readonly();
        op(ER, DA, 17'h800, 32'h0, 1'h0);
        op(ER, DA, 17'h1000, 32'h0, 1'h0);
        @(posedge clk);
        prot[1].read_only <= 1'h1;
        op(PG, DA, 17'h800, 32'h0, 1'h1);
        op(ER, DB, 17'hC00, 32'h0, 1'h1);
        op(RD, DB, 17'h804, ONES, 1'h0);
        op(RD, DA, 17'h800, ONES, 1'h0);
        op(PG, DA, 17'h1000, 32'h00005A5A, 1'h0);
        $display("t_readonly done");
    endtask : t_readonly

    task automatic t_exec();
        @(posedge clk);
        prot[2].exec_only <= 1'h1;
        op(RD, FE, 17'h1000, 32'h00005A5A, 1'h0);
        op(RD, DA, 17'h1000, 32'h0, 1'h1);
        op(RD, DB, 17'h1004, 32'h0, 1'h1);
        op(PG, FE, 17'h1000, 32'h0, 1'h1);
        op(ER, DA, 17'h1400, 32'h0, 1'h1);
        op(RD, FE, 17'h1000, 32'h00005A5A, 1'h0);
        $display("t_exec done");
    endtask : t_exec

    task automatic t_range();
        op(ER, DA, 17'h17C00, 32'h0, 1'h0);
        op(RD, DB, 17'h17FFC, ONES, 1'h0);
        op(RD, FE, 17'h18000, 32'h0, 1'h1);
        op(PG, DA, 17'h1FFFC, 32'h0, 1'h1);
        $display("t_range done");
    endtask : t_range

    task automatic t_viol();
        @(posedge clk);
        viol_clear <= 1'h1;
        @(posedge clk);
        viol_clear <= 1'h0;
        @(posedge clk);
        chk("viol_flag", 32'h0, 32'(viol_flag));
        op(RD, DA, 17'h1000, 32'h0, 1'h1);
        op(RD, DA, 17'h0, 32'h1200ABCD, 1'h0);
        chk("viol_flag", 32'h1, 32'(viol_flag));
        // Clear and a new refusal at one edge: the set must win
        fork
            op(RD, DB, 17'h1000, 32'h0, 1'h1);
            begin
                @(posedge clk);
                viol_clear <= 1'h1;
                @(posedge clk);
                viol_clear <= 1'h0;
            end
        join
        chk("viol_flag", 32'h1, 32'(viol_flag));
        $display("t_viol done");
    endtask : t_viol

    task automatic t_reset();
        @(posedge clk);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        chk("viol_flag", 32'h0, 32'(viol_flag));
        chk("req_ready", 32'h1, 32'(req_ready));
        chk("rsp_valid", 32'h0, 32'(rsp_valid));
        rstn <= 1'h1;
        // The array keeps its contents over a reset
        op(RD, FE, 17'h0, 32'h1200ABCD, 1'h0);
        $display("t_reset done");
    endtask : t_reset

    initial begin
        clk = 1'h0;
        rstn = 1'h0;
        viol_clear = 1'h0;
        prot = '0;
        fails = 0;
        checked = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'h1;
        t_erase();
        t_readonly();
        t_exec();
        t_range();
        t_viol();
        t_reset();
        give_verdict();
    end
endmodule : flash_block_protection_test
`default_nettype wire
